//--- mrs_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ps
module mrs_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];                         // storage
  logic [AW:0]  wp_reg, wp_next, rp_reg, rp_next; // pointers with wrap bit
  logic         push, pop;

  assign in_ready  = (wp_reg - rp_reg) != (AW+1)'(D);
  assign out_valid = wp_reg != rp_reg;
  assign out_data  = mem[rp_reg[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer next values
  always_comb begin
    wp_next = push ? wp_reg + 1'b1 : wp_reg;
    rp_next = pop  ? rp_reg + 1'b1 : rp_reg;
  end

  // pointer registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
  end

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_reg[AW-1:0]] <= in_data;
    end
  end
endmodule

//--- mrs_framer.sv
// rtu slave framer: uart, silence timing, address filter, crc and reply
//------------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------------
// Overview of operation
// - address zero is broadcast, never answered
// - answer own address, ignore others
// - bad request yields exception reply
// - start bit, eight data bits, lsb first
// - optional even or odd parity bit
// - one stop with parity, two without
// - baud selectable 2400 to 115200
// - reset format is even parity, one stop
// - receiver watches line continuously
// - first byte is address, decoded at once
// - short telegrams flagged as error
// - address, function, data, crc in order
// - any byte value 00 to FF allowed
// - reply echoes action, data, own crc
// - crc covers whole telegram
// - 3.5 character silence frames telegrams
// - gap over 1.5 chars flushes partial
// - own address configurable 1 to 247
// - crc low byte first; mismatch no reply
`timescale 1ns/1ps
module mrs_framer
  import mrs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       rxd,            // rs485 receive data
  output logic            txd,            // rs485 transmit data
  output logic            tx_oe,          // driver enable while sending
  input  wire mrs_par_t   cfg_parity,     // parity select
  input  wire logic       cfg_set,        // load format, address, baud
  input  wire logic [7:0] cfg_addr,       // own station address
  input  wire logic [15:0] cfg_div16,     // clk cycles per 1/16 bit
  output mrs_word_t       rx_word,        // query bytes to application
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic            rx_bcast,       // query is broadcast
  output logic            rx_err,         // short telegram or parity error pulse
  output logic            frame_ok,       // good query, crc matched, pulse
  input  wire logic       rsp_go,         // application reply ready
  input  wire logic       rsp_exc,        // request failed: exception
  input  wire logic [7:0] rsp_code,       // exception code
  input  wire mrs_word_t  rsp_word,       // reply data bytes after function
  input  wire logic       rsp_valid,
  output logic            rsp_ready,
  output logic            busy            // transmitting a reply
);
  //------------------------------------------------------------------
  // configuration
  //------------------------------------------------------------------
  mrs_cfg_t cfg_reg, cfg_next;
  // next configuration: an illegal own address leaves everything unchanged
  always_comb begin
    cfg_next = cfg_reg;
    if (cfg_set && cfg_addr >= ADDR_MIN && cfg_addr <= ADDR_MAX)
      cfg_next = '{cfg_parity, cfg_addr, cfg_div16};
  end
  // configuration register, even parity and one stop out of reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) cfg_reg <= '{MRS_PAR_EVEN, ADDR_MIN, 16'(CLK_HZ / (DEF_BAUD * OVS))};
    else cfg_reg <= cfg_next;
  end

  //------------------------------------------------------------------
  // oversample tick and half-character tick
  //------------------------------------------------------------------
  logic [15:0] div_reg, div_next;
  logic [7:0]  hc_reg, hc_next;      // ticks toward half character
  logic        tick, htick;
  assign tick  = (div_reg == 16'h0000);
  assign htick = tick && (hc_reg == 8'h00);
  always_comb begin
    div_next = tick ? cfg_reg.div16 - 16'h0001 : div_reg - 16'h0001;
    hc_next  = hc_reg;
    if (tick) hc_next = (hc_reg == 8'h00) ? 8'((BITS_CHAR * OVS) / 2 - 1) : hc_reg - 8'h01;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= 16'h0000;
      hc_reg  <= 8'h00;
    end else begin
      div_reg <= div_next;
      hc_reg  <= hc_next;
    end
  end

  //------------------------------------------------------------------
  // receiver
  //------------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_BITS = 2'b01, RX_STOP = 2'b10
  } mrs_rxs_t;
  mrs_rxs_t    rs_reg, rs_next;
  logic [3:0]  rt_reg, rt_next;     // oversample count
  logic [3:0]  rb_reg, rb_next;     // bit index
  logic [8:0]  rsh_reg, rsh_next;   // data plus parity
  logic        rdone, rperr;        // byte done pulse, parity bad
  logic [3:0]  nbits;
  assign nbits = (cfg_reg.parity == MRS_PAR_NONE) ? 4'(DATA_BITS) : 4'(DATA_BITS + 1);
  // receiver next state: each bit sampled at its centre tick
  always_comb begin
    rs_next = rs_reg; rt_next = rt_reg; rb_next = rb_reg; rsh_next = rsh_reg;
    rdone = 1'b0; rperr = 1'b0;
    unique case (rs_reg)
      RX_IDLE: if (!rxd) begin  // start edge seen at any time
        rs_next = RX_BITS; rt_next = 4'h0; rb_next = 4'hF;
      end
      RX_BITS: if (tick) begin
        rt_next = rt_reg + 4'h1;
        if (rt_reg == 4'(OVS_MID)) begin
          if (rb_reg == 4'hF && rxd) rs_next = RX_IDLE; // glitch start
          else if (rb_reg != 4'hF) rsh_next = {rxd, rsh_reg[8:1]}; // lsb first
          rb_next = rb_reg + 4'h1;
          if (rb_reg + 4'h1 == nbits) rs_next = RX_STOP;
        end
      end
      RX_STOP: if (tick) begin
        rt_next = rt_reg + 4'h1;
        if (rt_reg == 4'(OVS_MID)) begin // first stop is enough to resync
          rdone = 1'b1;
          rs_next = RX_IDLE;
          if (cfg_reg.parity != MRS_PAR_NONE)
            rperr = (^rsh_reg) ^ (cfg_reg.parity == MRS_PAR_ODD) | !rxd;
          else rperr = !rxd;
        end
      end
      default: rs_next = RX_IDLE;
    endcase
  end
  logic [7:0] rbyte;
  assign rbyte = (cfg_reg.parity == MRS_PAR_NONE) ? rsh_reg[8:1] : rsh_reg[7:0];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rs_reg <= RX_IDLE; rt_reg <= 4'h0; rb_reg <= 4'h0; rsh_reg <= 9'h000;
    end else begin
      rs_reg <= rs_next; rt_reg <= rt_next; rb_reg <= rb_next; rsh_reg <= rsh_next;
    end
  end

  //------------------------------------------------------------------
  // telegram framing, crc check, reply build
  //------------------------------------------------------------------
  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) r = r[0] ? (r >> 1) ^ CRC_POLY : (r >> 1);
    return r;
  endfunction

  typedef enum logic [2:0] {
    FR_WAIT = 3'b000, FR_ADDR = 3'b001, FR_BODY = 3'b010, FR_SKIP = 3'b011,
    FR_END  = 3'b100, FR_RSP  = 3'b101, FR_TX   = 3'b110
  } mrs_frs_t;
  mrs_frs_t    fs_reg, fs_next;
  logic [3:0]  gap_reg, gap_next;    // silence in half characters
  logic [15:0] crc_reg, crc_next;
  logic [15:0] tail_reg, tail_next;  // last two bytes seen
  logic [8:0]  cnt_reg, cnt_next;    // bytes received
  logic        bc_reg, bc_next, er_reg, er_next;
  logic [7:0]  fn_reg, fn_next;
  logic        fok, ferr, push_v;
  mrs_word_t   push_w;
  logic        f_ready;
  // application side fifo for query bytes
  mrs_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk(clk), .resetn(resetn), .in_data(push_w), .in_valid(push_v),
    .in_ready(f_ready), .out_data(rx_word), .out_valid(rx_valid), .out_ready(rx_ready));

  // tx shared signals
  logic        tx_start, tx_busy;
  logic [7:0]  tx_byte;
  logic [2:0]  ph_reg, ph_next;      // reply field phase
  logic        tlast_reg, tlast_next;

  // framing next state: silence count, address filter, crc, reply phases
  always_comb begin
    fs_next = fs_reg; gap_next = gap_reg; crc_next = crc_reg; tail_next = tail_reg;
    cnt_next = cnt_reg; bc_next = bc_reg; er_next = er_reg; fn_next = fn_reg;
    ph_next = ph_reg; tlast_next = tlast_reg;
    fok = 1'b0; ferr = 1'b0; push_v = 1'b0; push_w = '{1'b0, rbyte};
    tx_start = 1'b0; tx_byte = 8'h00; rsp_ready = 1'b0;
    if (rdone || rs_reg != RX_IDLE) gap_next = 4'h0; // restart on character
    else if (htick && gap_reg != 4'hF) gap_next = gap_reg + 4'h1;
    unique case (fs_reg)
      FR_WAIT: if (gap_reg >= 4'(T35_X2)) fs_next = FR_ADDR;
      FR_ADDR: if (rdone) begin
        crc_next = crc8(CRC_INIT, rbyte); cnt_next = 9'h001; er_next = rperr;
        bc_next = (rbyte == BCAST_ADDR);
        fs_next = (rbyte == BCAST_ADDR || rbyte == cfg_reg.addr) ? FR_BODY : FR_SKIP;
      end
      FR_SKIP: if (gap_reg >= 4'(T35_X2)) fs_next = FR_ADDR;
      FR_BODY: begin
        if (rdone) begin
          crc_next = crc8(crc_reg, rbyte); tail_next = {rbyte, tail_reg[15:8]};
          cnt_next = cnt_reg + 9'h001; er_next = er_reg | rperr;
          if (cnt_reg == 9'h001) fn_next = rbyte;
          if (cnt_reg >= 9'h004) push_v = f_ready; // data byte two behind
          push_w = '{1'b0, tail_reg[7:0]};
          if (cnt_reg == 9'(MAX_RX) || (cnt_reg >= 9'h004 && !f_ready)) er_next = 1'b1;
        end else if (gap_reg > 4'(T15_X2)) begin // silence ends frame
          fs_next = FR_END;
        end
      end
      FR_END: if (rdone) begin // restarted early: telegram dropped without crc check, rest skipped
        fs_next = FR_SKIP;
      end else if (gap_reg >= 4'(T35_X2)) begin
        if (cnt_reg < 9'h004) begin ferr = 1'b1; fs_next = FR_ADDR; end
        else if (crc_reg != 16'h0000 || er_reg) fs_next = FR_ADDR; // silent
        else begin
          fok = 1'b1;
          fs_next = bc_reg ? FR_ADDR : FR_RSP;
        end
      end
      FR_RSP: if (rsp_go) begin
        fs_next = FR_TX; ph_next = 3'h0; crc_next = CRC_INIT; tlast_next = 1'b0;
        fn_next = rsp_exc ? (fn_reg | EXC_FLAG) : fn_reg;
        er_next = rsp_exc;
      end
      FR_TX: if (!tx_busy && ph_reg == 3'h6) begin // driver held until last stop is out
        fs_next = FR_WAIT;
      end else if (!tx_busy) begin
        tx_start = 1'b1;
        unique case (ph_reg)
          3'h0: tx_byte = cfg_reg.addr;   // own address back
          3'h1: tx_byte = fn_reg;
          3'h2: tx_byte = rsp_code;       // exception code
          3'h3: tx_byte = rsp_word.data;
          3'h4: tx_byte = crc_reg[7:0];   // low byte first
          default: tx_byte = crc_reg[15:8];
        endcase
        if (ph_reg == 3'h3 && !rsp_valid) tx_start = 1'b0;
        if (tx_start) begin
          if (ph_reg < 3'h4) crc_next = crc8(crc_reg, tx_byte);
          unique case (ph_reg)
            3'h1: ph_next = er_reg ? 3'h2 : (tlast_reg ? 3'h4 : 3'h3);
            3'h2: ph_next = 3'h4;
            3'h3: begin rsp_ready = 1'b1; if (rsp_word.last) ph_next = 3'h4; end
            default: ph_next = ph_reg + 3'h1;
          endcase
        end
      end
      default: fs_next = FR_WAIT;
    endcase
    if (rdone && rperr && fs_reg == FR_BODY) ferr = 1'b1; // flag reception error
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fs_reg <= FR_WAIT; gap_reg <= 4'h0; crc_reg <= CRC_INIT; tail_reg <= 16'h0000;
      cnt_reg <= 9'h000; bc_reg <= 1'b0; er_reg <= 1'b0; fn_reg <= 8'h00;
      ph_reg <= 3'h0; tlast_reg <= 1'b0;
    end else begin
      fs_reg <= fs_next; gap_reg <= gap_next; crc_reg <= crc_next; tail_reg <= tail_next;
      cnt_reg <= cnt_next; bc_reg <= bc_next; er_reg <= er_next; fn_reg <= fn_next;
      ph_reg <= ph_next; tlast_reg <= tlast_next;
    end
  end
  logic ok_reg, err_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin ok_reg <= 1'b0; err_reg <= 1'b0; end
    else begin ok_reg <= fok; err_reg <= ferr; end
  end
  assign frame_ok = ok_reg;
  assign rx_err   = err_reg;
  assign rx_bcast = bc_reg;
  assign busy     = (fs_reg == FR_TX);

  //------------------------------------------------------------------
  // transmitter: start, data lsb first, parity, stops
  //------------------------------------------------------------------
  logic [11:0] tsh_reg, tsh_next;   // remaining bits, lsb out first
  logic [3:0]  tn_reg, tn_next, tt_reg, tt_next;
  logic        tpar;
  assign tx_busy = (tn_reg != 4'h0);
  always_comb begin
    tsh_next = tsh_reg; tn_next = tn_reg; tt_next = tt_reg;
    tpar = (^tx_byte) ^ (cfg_reg.parity == MRS_PAR_ODD);
    if (tx_start) begin
      tsh_next = (cfg_reg.parity == MRS_PAR_NONE) ? {2'b11, 1'b1, tx_byte, 1'b0}
                                                   : {2'b11, tpar, tx_byte, 1'b0};
      tn_next = 4'(BITS_CHAR); tt_next = 4'h0;
    end else if (tx_busy && tick) begin
      tt_next = tt_reg + 4'h1;
      if (tt_reg == 4'(OVS - 1)) begin
        tsh_next = {1'b1, tsh_reg[11:1]};
        tn_next = tn_reg - 4'h1;
      end
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tsh_reg <= 12'hFFF; tn_reg <= 4'h0; tt_reg <= 4'h0;
    end else begin
      tsh_reg <= tsh_next; tn_reg <= tn_next; tt_reg <= tt_next;
    end
  end
  assign txd   = tx_busy ? tsh_reg[0] : 1'b1;
  assign tx_oe = busy; // drive only while replying
endmodule

//--- mrs_framer_bench.sv
// self-checking bench for the rtu slave framer
`timescale 1ns/1ps
module mrs_framer_bench
  import mrs_pkg::*;
();
  localparam logic [15:0] DIV = 16'h0002;  // two clk per tick, fast line keeps the run short
  localparam int          BC  = 32;        // clk cycles per bit at DIV
  logic        clk, resetn, rxd, txd, tx_oe, cfg_set, rx_valid, rx_ready, rx_bcast, rx_err;
  logic        frame_ok, rsp_go, rsp_exc, rsp_valid, rsp_ready, busy, hold, txo_q;
  mrs_par_t    cfg_parity;
  logic [7:0]  cfg_addr, rsp_code, own;
  logic [15:0] cfg_div16;
  mrs_word_t   rx_word, rsp_word;
  logic [7:0]  expq[$], rspq[$];  // model: fifo bytes due, reply words
  int          fail_count = 0, compares = 0, n_ok = 0, n_err = 0, n_tx = 0;
  mrs_framer u_mrs_framer (.clk(clk), .resetn(resetn), .rxd(rxd), .txd(txd), .tx_oe(tx_oe),
    .cfg_parity(cfg_parity), .cfg_set(cfg_set), .cfg_addr(cfg_addr), .cfg_div16(cfg_div16),
    .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_bcast(rx_bcast),
    .rx_err(rx_err), .frame_ok(frame_ok), .rsp_go(rsp_go), .rsp_exc(rsp_exc),
    .rsp_code(rsp_code), .rsp_word(rsp_word), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .busy(busy));
  mrs_master u_mrs_master (.clk(clk), .rxd(rxd), .txd(txd), .tx_oe(tx_oe));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // event counters and fifo compare, looked at where outputs have settled
  always @(negedge clk) begin
    txo_q <= tx_oe;
    if (tx_oe === 1'b1 && txo_q === 1'b0) n_tx++;
    if (frame_ok === 1'b1) n_ok++;
    if (rx_err === 1'b1) n_err++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) check(rx_word, expq.pop_front(), "fifo");
    if (rsp_valid === 1'b1 && rsp_ready === 1'b1) void'(rspq.pop_front());
  end
  // reply feed and random stalls, driven on the rising edge
  always @(posedge clk) begin
    rsp_valid <= rspq.size() > 0;
    rsp_word  <= {rspq.size() == 1, (rspq.size() > 0) ? rspq[0] : 8'h00};
    rx_ready  <= !hold && ($urandom % 4 != 0);
  end
  task automatic setcfg(input mrs_par_t p, input logic [7:0] a);
    @(posedge clk);
    cfg_parity <= p;
    cfg_addr   <= a;
    cfg_set    <= 1'b1;
    @(posedge clk);
    cfg_set <= 1'b0;
    if (a >= ADDR_MIN && a <= ADDR_MAX) u_mrs_master.par = p;
    repeat (44 * BC) @(posedge clk);
  endtask
  // one query, then a reply offer; model predicts every result
  task automatic run(input logic [7:0] a, input int nd, input bit bad, input int keep,
                     input bit exc, input int nr);
    logic [7:0] q[$], e[$];
    logic [15:0] c;
    int ok0, er0, tx0, lim;
    bit full, due;
    {ok0, er0, tx0} = {n_ok, n_err, n_tx};
    full = keep >= nd + 4;
    due = a == own && full && !bad;
    q = {a, 8'h01 + 8'($urandom % 127)};
    for (int i = 0; i < nd; i++) begin
      q.push_back(8'($urandom));
      if (a == own || a == BCAST_ADDR) expq.push_back(q[i + 2]);
    end
    u_mrs_master.got.delete();
    u_mrs_master.query(q, bad, keep);
    check(n_ok - ok0, full && !bad && (a == own || a == BCAST_ADDR), "good");
    check(n_err - er0, !full, "short telegram");
    if (due || a == BCAST_ADDR) check(rx_bcast, a == BCAST_ADDR, "bcast flag");
    e = {own, exc ? (q[1] | EXC_FLAG) : q[1]};
    @(posedge clk);
    rsp_go   <= 1'b1;
    rsp_exc  <= exc;
    rsp_code <= 8'h02;
    if (exc) e.push_back(8'h02);
    for (int i = 0; i < nr; i++) rspq.push_back(8'($urandom));
    if (!exc) e = {e, rspq};
    @(posedge clk);
    rsp_go <= 1'b0;
    c = u_mrs_master.crc16(e);
    e = {e, c[7:0], c[15:8]};
    lim = due ? 30000 : 22 * BC;
    for (int i = 0; i < lim && !(n_tx > tx0 && busy === 1'b0 && tx_oe === 1'b0); i++)
      @(posedge clk);
    check(n_tx - tx0, due, "reply count");
    if (due) check(u_mrs_master.got.size(), e.size(), "reply length");
    if (due) foreach (e[i]) check(u_mrs_master.got[i], e[i], "reply byte");
    if (due) repeat (44 * BC) @(posedge clk);
    rspq.delete();
  endtask
  initial begin
    resetn = 1'b0;
    {cfg_set, rsp_go, rsp_exc, rsp_valid, rx_ready, hold, txo_q} = '0;
    cfg_parity = MRS_PAR_EVEN;
    {cfg_addr, cfg_div16, rsp_code} = {8'h01, DIV, 8'h00};
    rsp_word = '0;
    void'($urandom(32'h42d0));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    own = 8'h01 + 8'($urandom % 247);
    setcfg(MRS_PAR_EVEN, own);
    setcfg(MRS_PAR_EVEN, 8'hF8);
    run(own, 2, 0, 99, 0, 2);
    run(own, 1, 0, 99, 1, 0);
    run(BCAST_ADDR, 2, 0, 99, 0, 1);
    run(8'hF8, 2, 0, 99, 0, 1);
    run(own, 2, 1, 99, 0, 1);
    run(own, 0, 0, 2, 0, 1);
    hold = 1'b1;
    run(own, FIFO_D, 0, 99, 0, 3);
    check(rx_valid, 1'b1, "fifo full");
    hold = 1'b0;
    repeat (200) @(posedge clk);
    check(expq.size(), 0, "fifo drained");
    for (int m = 0; m < 3; m++) begin
      setcfg(mrs_par_t'(m), own);
      run(own, 1 + $urandom % 4, 0, 99, 0, 1 + $urandom % 4);
    end
    check(u_mrs_master.ferr, 0, "reply format");
    test_done();
  end
  // watchdog
  initial begin
    repeat (99000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule

//--- mrs_framer_sva.sv
// assertion checker for the rtu slave framer
`timescale 1ns/1ps
module mrs_framer_sva
  import mrs_pkg::*;
(
  input wire logic      clk,
  input wire logic      resetn,
  input wire logic      txd,
  input wire logic      tx_oe,
  input wire mrs_word_t rx_word,
  input wire logic      rx_valid,
  input wire logic      rx_ready,
  input wire logic      rx_bcast,
  input wire logic      rx_err,
  input wire logic      frame_ok
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  //----------
  // helper
  //----------
  logic ok_seen_reg;   // good query waiting for its reply
  logic ok_seen_next;  // next value
  // armed by frame_ok, spent when the driver turns on
  always_comb begin
    ok_seen_next = ok_seen_reg;
    if (tx_oe) begin
      ok_seen_next = 1'b0;
    end
    if (frame_ok) begin
      ok_seen_next = 1'b1;
    end
  end
  // register only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ok_seen_reg <= 1'b0;
    end else begin
      ok_seen_reg <= ok_seen_next;
    end
  end
  //----------
  // properties
  //----------
  a_idle_line_high: assert property (!tx_oe |-> txd)
    else $error("line not idle high with driver off");
  a_ok_one_cycle: assert property (frame_ok |=> !frame_ok)
    else $error("frame ok longer than one cycle");
  a_err_one_cycle: assert property (rx_err |=> !rx_err)
    else $error("error pulse longer than one cycle");
  a_err_not_ok: assert property (rx_err |-> !frame_ok)
    else $error("short telegram also reported good");
  a_reply_after_ok: assert property ($rose(tx_oe) |-> ok_seen_reg)
    else $error("reply without a good query");
  a_bcast_silent: assert property (rx_bcast |-> !tx_oe)
    else $error("driver on for a broadcast");
  a_ok_not_in_tx: assert property (frame_ok |-> !tx_oe)
    else $error("query accepted while replying");
  a_fifo_word_held: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
    else $error("fifo head changed while stalled");
  a_last_flag_clear: assert property (rx_valid |-> !rx_word.last)
    else $error("last marker set on query byte");
  a_reply_held_on: assert property ($rose(tx_oe) |=> tx_oe [*8])
    else $error("driver dropped inside reply");
  c_good_query: cover property (frame_ok);
  c_short_query: cover property (rx_err);
  c_reply: cover property ($rose(tx_oe));
  c_fifo_stall: cover property (rx_valid && !rx_ready);
endmodule
bind mrs_framer mrs_framer_sva u_mrs_framer_sva (.clk(clk), .resetn(resetn), .txd(txd),
  .tx_oe(tx_oe), .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .rx_bcast(rx_bcast), .rx_err(rx_err), .frame_ok(frame_ok));

//--- mrs_master.sv
// bus master model: sends queries, decodes replies
`timescale 1ns/1ps
module mrs_master
  import mrs_pkg::*;
(
  input  wire logic clk,
  output logic      rxd,
  input  wire logic txd,
  input  wire logic tx_oe
);
  int         bitc = 32;            // clk cycles per bit
  mrs_par_t   par  = MRS_PAR_EVEN;  // character format
  logic [7:0] got[$];               // reply bytes heard
  int         ferr = 0;             // bad parity or stop heard
  initial rxd = 1'b1;               // biased bus idles high
  // crc preset all ones, reflected polynomial
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
  // one character, bits change on clock edges
  task automatic send_char(input logic [7:0] d);
    logic b[$];
    b = {1'b0};
    for (int i = 0; i < 8; i++) b.push_back(d[i]);
    if (par != MRS_PAR_NONE) b.push_back((par == MRS_PAR_ODD) ^ (^d));
    b.push_back(1'b1);
    if (par == MRS_PAR_NONE) b.push_back(1'b1);
    foreach (b[i]) begin
      rxd <= b[i];
      repeat (bitc) @(posedge clk);
    end
  endtask
  // query, crc low byte first, then closing silence
  task automatic query(input logic [7:0] q[$], input bit bad, input int keep);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    for (int i = 0; i < keep && i < q.size(); i++) send_char(q[i]);
    repeat (44 * bitc) @(posedge clk);
  endtask
  // reply decoder, samples at bit centres
  initial begin
    logic [7:0] d;
    forever begin
      @(negedge txd);
      repeat (bitc / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bitc) @(posedge clk);
        d[i] = txd;
      end
      if (par != MRS_PAR_NONE) begin
        repeat (bitc) @(posedge clk);
        if (txd !== ((par == MRS_PAR_ODD) ^ (^d))) ferr++;
      end
      for (int s = 0; s < ((par == MRS_PAR_NONE) ? 2 : 1); s++) begin
        repeat (bitc) @(posedge clk);
        if (txd !== 1'b1) ferr++;
      end
      got.push_back(d);
    end
  end
endmodule

//--- mrs_pkg.sv
// shared constants and types for the rtu slave framer
package mrs_pkg;
  localparam int unsigned CLK_HZ      = 25000000;        // system clock rate
  localparam int unsigned DEF_BAUD    = 19200;           // line rate out of reset
  localparam logic [7:0]  BCAST_ADDR  = 8'h00;           // broadcast station
  localparam logic [7:0]  ADDR_MIN    = 8'h01;           // lowest own address
  localparam logic [7:0]  ADDR_MAX    = 8'hF7;           // highest own address
  localparam logic [15:0] CRC_INIT    = 16'hFFFF;        // crc preset
  localparam logic [15:0] CRC_POLY    = 16'hA001;        // reflected polynomial
  localparam logic [7:0]  EXC_FLAG    = 8'h80;           // exception bit of function
  localparam logic [7:0]  EXC_CRC     = 8'h04;           // fallback exception code
  localparam int unsigned OVS         = 16;              // rx oversample ticks per bit
  localparam int unsigned OVS_MID     = 8;               // tick at bit centre
  localparam int unsigned DATA_BITS   = 8;               // data bits per character
  localparam int unsigned FIFO_W      = 9;               // last flag plus byte
  localparam int unsigned FIFO_D      = 16;              // fifo depth
  localparam int unsigned T15_X2      = 3;               // 1.5 chars in half chars
  localparam int unsigned T35_X2      = 7;               // 3.5 chars in half chars
  localparam int unsigned BITS_CHAR   = 11;              // bits per character, all formats
  localparam int unsigned MAX_RX      = 256;             // longest query bytes

  // parity selection, reset default even
  typedef enum logic [1:0] {
    MRS_PAR_NONE = 2'b00,
    MRS_PAR_EVEN = 2'b01,
    MRS_PAR_ODD  = 2'b10
  } mrs_par_t;

  // line format and baud setting
  typedef struct packed {
    mrs_par_t   parity;   // parity mode
    logic [7:0] addr;     // own station address
    logic [15:0] div16;   // clk cycles per 1/16 bit
  } mrs_cfg_t;

  // byte stream word: byte plus last marker
  typedef struct packed {
    logic       last;     // final data byte, crc follows
    logic [7:0] data;     // byte value
  } mrs_word_t;
endpackage
